// >>> design/asp_consts.svh
// Constants for the converter serial port: register selects, sizes, resets, timing.
// Assumes inclusion by bare name from the design file.
`ifndef ASP_CONSTS_SVH
`define ASP_CONSTS_SVH
`define ASP_SEL_STATUS 2'h0
`define ASP_SEL_MODE 2'h1
`define ASP_SEL_FILTER 2'h2
`define ASP_SEL_DATA 2'h3
`define ASP_CR_SEL_HI 5
`define ASP_CR_SEL_LO 4
`define ASP_CR_DIR 3
`define ASP_STATUS_RST 8'h88
`define ASP_STATUS_RDY 7
`define ASP_MODE_RST 8'h02
`define ASP_FILTER_RST 8'h04
`define ASP_DATA_RST 16'h0000
`define ASP_ONES_LAST 5'h1f
`define ASP_LEN_REG 5'h07
`define ASP_LEN_DATA 5'h0f
`define ASP_UPD_NS 100
`define ASP_CLK_NS 4
`define ASP_UPD_CYC ((`ASP_UPD_NS + `ASP_CLK_NS - 1) / `ASP_CLK_NS)
`endif

// >>> design/asp_pkg.sv
// Types for the converter serial port.
// Assumes nothing beyond the constants header.
package asp_pkg;
  typedef enum logic [2:0] {
    ASP_COMM = 3'b001,
    ASP_WR = 3'b010,
    ASP_RD = 3'b100
  } asp_link_state_t;
endpackage

// >>> design/asp_port.sv
// Serial host port of a sigma-delta converter, with its result FIFO.
// Assumes sclk_i and cs_n_i come from one host; cs_n_i is steady around sclk edges.
`timescale 1ns/1ps
`include "asp_consts.svh"

module asp_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic space;
  wire full = !space;
  wire push = in_valid_i && !full;
  wire pop = out_valid_o && out_ready_i;
  wire [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign in_ready_o = space;
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  always_ff @(posedge clk_sys_i)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_i;
    end
  end
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      space <= 1'b1;
    end
    else
    begin
      wr_ptr <= push ? AW'(wr_ptr + 1'b1) : wr_ptr;
      rd_ptr <= pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
      count <= next_count;
      // Room kept as a flop so the source sees a registered ready
      space <= (next_count != (AW+1)'(D));
    end
  end
endmodule // asp_fifo

// How it works
// - Read bits are launched on falling serial clock, valid at next rise.
// - Completed conversion drives the shared pin and ready bit low.
// - Unread result: ready returns high one cycle before the next update.
// - Ready bit kept in status; pin released while chip select is high.
// - Chip select active low; tied low gives a working three-wire port.
// - Serial clock may burst or stop; bit position is held meanwhile.
// - Written word goes to the mode or filter register chosen by the last command word; data writes are dropped.
// - Output shifter loads from whichever register the read selects.
// - Each access starts with a command word; after it, back to waiting.
// - Thirty-two ones in a row reset the port and the mode, filter, data and ready registers; the FIFO keeps its contents.
// - First command bit high holds position; once low, seven more follow.
// - Direction bit: zero writes the selected register (status excepted: no write follows), one reads it.
module asp_port #(
  parameter int FIFO_DEPTH = 16,
  parameter int UPD_CYC = `ASP_UPD_CYC
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_o,
  input wire logic conv_valid_i,
  output logic conv_ready_o,
  input wire logic [15:0] conv_data_i,
  output logic [7:0] mode_o,
  output logic [7:0] filter_o,
  output logic rdy_n_o
);
  // Link domain
  logic [1:0] lrst_s;
  logic [2:0] rdy_s;
  logic rdy_l;
  asp_pkg::asp_link_state_t state;
  logic [4:0] cnt;
  logic [4:0] ones;
  logic [6:0] comm_sh;
  logic [1:0] sel;
  logic [15:0] sh;
  logic [15:0] rd_word;
  logic [4:0] idx;
  logic [1:0] wr_addr;
  logic [15:0] wr_data;
  logic wr_tog;
  logic rd_tog;
  logic rst_tog;
  logic busy;
  logic dout_q;
  // System domain
  logic [2:0] wr_s;
  logic [2:0] rd_s;
  logic [2:0] rst_s;
  logic [2:0] busy_s;
  logic [2:0] cs_s;
  logic [7:0] mode;
  logic [7:0] filter;
  logic [15:0] data;
  logic rdy_n;
  logic oe;
  logic [15:0] snap [4];
  logic [$clog2(UPD_CYC+1)-1:0] gap;
  logic fifo_ov;
  logic [15:0] fifo_od;

  wire [7:0] word = {comm_sh, din_i};
  wire [1:0] word_sel = word[`ASP_CR_SEL_HI:`ASP_CR_SEL_LO];
  wire word_rd = word[`ASP_CR_DIR];
  wire ones_hit = din_i && (ones == `ASP_ONES_LAST);
  wire [4:0] word_len = (word_sel == `ASP_SEL_DATA) ? `ASP_LEN_DATA : `ASP_LEN_REG;
  wire [4:0] wr_len = (sel == `ASP_SEL_DATA) ? `ASP_LEN_DATA : `ASP_LEN_REG;
  wire wr_ev = wr_s[2] ^ wr_s[1];
  wire rd_ev = rd_s[2] ^ rd_s[1];
  wire rst_ev = rst_s[2] ^ rst_s[1];
  wire can_upd = (gap == '0) && fifo_ov;
  wire fifo_pop = can_upd && !rdy_n;
  wire fifo_load = can_upd && rdy_n && !rst_ev;

  assign dout_o = dout_q;
  assign dout_oe_o = oe;
  assign mode_o = mode;
  assign filter_o = filter;
  assign rdy_n_o = rdy_n;

  // Reset reaches the link side as a level; it takes effect on sclk edges
  always_ff @(posedge sclk_i)
  begin
    lrst_s <= {lrst_s[0], reset_i};
    rdy_s <= {rdy_s[1:0], rdy_n};
    if (rdy_s[2] == rdy_s[1])
    begin
      rdy_l <= rdy_s[2];
    end
  end

  always_ff @(posedge sclk_i)
  begin
    if (lrst_s[1])
    begin
      state <= asp_pkg::ASP_COMM;
      cnt <= 5'h00;
      ones <= 5'h00;
      comm_sh <= 7'h00;
      sel <= `ASP_SEL_STATUS;
      sh <= 16'h0000;
      rd_word <= 16'h0000;
      idx <= 5'h00;
      wr_addr <= `ASP_SEL_STATUS;
      wr_data <= 16'h0000;
      wr_tog <= 1'b0;
      rd_tog <= 1'b0;
      rst_tog <= 1'b0;
      busy <= 1'b0;
    end
    else if (!cs_n_i)
    begin
      ones <= din_i ? 5'(ones + 1'b1) : 5'h00;
      if (ones_hit)
      begin
        state <= asp_pkg::ASP_COMM;
        cnt <= 5'h00;
        ones <= 5'h00;
        busy <= 1'b0;
        rst_tog <= !rst_tog;
      end
      else
      begin
        case (state)
          asp_pkg::ASP_COMM:
          begin
            if (cnt == 5'h00 && din_i)
            begin
              busy <= 1'b0;
            end
            else if (cnt == 5'h07)
            begin
              cnt <= 5'h00;
              sel <= word_sel;
              if (word_rd)
              begin
                state <= asp_pkg::ASP_RD;
                rd_word <= snap[word_sel];
                idx <= word_len;
              end
              else if (word_sel != `ASP_SEL_STATUS)
              begin
                state <= asp_pkg::ASP_WR;
              end
              else
              begin
                busy <= 1'b0;
              end
            end
            else
            begin
              comm_sh <= word[6:0];
              cnt <= 5'(cnt + 1'b1);
              busy <= 1'b1;
            end
          end
          asp_pkg::ASP_WR:
          begin
            sh <= {sh[14:0], din_i};
            cnt <= 5'(cnt + 1'b1);
            if (cnt == wr_len)
            begin
              wr_addr <= sel;
              wr_data <= {sh[14:0], din_i};
              wr_tog <= !wr_tog;
              cnt <= 5'h00;
              busy <= 1'b0;
              state <= asp_pkg::ASP_COMM;
            end
          end
          asp_pkg::ASP_RD:
          begin
            idx <= 5'(idx - 1'b1);
            if (idx == 5'h00)
            begin
              state <= asp_pkg::ASP_COMM;
              busy <= 1'b0;
              rd_tog <= (sel == `ASP_SEL_DATA) ? !rd_tog : rd_tog;
            end
          end
          default:
          begin
            state <= asp_pkg::ASP_COMM;
            cnt <= 5'h00;
          end
        endcase
      end
    end
  end

  // Falling edge launches read bits; otherwise the pin shows ready
  always_ff @(negedge sclk_i)
  begin
    if (state == asp_pkg::ASP_RD)
    begin
      dout_q <= rd_word[idx[3:0]];
    end
    else
    begin
      dout_q <= rdy_l;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      wr_s <= 3'h0;
      rd_s <= 3'h0;
      rst_s <= 3'h0;
      busy_s <= 3'h0;
      cs_s <= 3'h7;
      oe <= 1'b0;
    end
    else
    begin
      wr_s <= {wr_s[1:0], wr_tog};
      rd_s <= {rd_s[1:0], rd_tog};
      rst_s <= {rst_s[1:0], rst_tog};
      busy_s <= {busy_s[1:0], busy};
      cs_s <= {cs_s[1:0], cs_n_i};
      if (cs_s[2] == cs_s[1])
      begin
        oe <= !cs_s[2];
      end
    end
  end

  // Snapshot frozen while a command or access is running, so the link reads a steady word
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      snap[0] <= {8'h00, `ASP_STATUS_RST};
      snap[1] <= {8'h00, `ASP_MODE_RST};
      snap[2] <= {8'h00, `ASP_FILTER_RST};
      snap[3] <= `ASP_DATA_RST;
    end
    else if (!(busy_s[2] || busy_s[1]))
    begin
      snap[0] <= {8'h00, rdy_n, 7'(`ASP_STATUS_RST)};
      snap[1] <= {8'h00, mode};
      snap[2] <= {8'h00, filter};
      snap[3] <= data;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i || rst_ev)
    begin
      mode <= `ASP_MODE_RST;
      filter <= `ASP_FILTER_RST;
      data <= `ASP_DATA_RST;
      rdy_n <= 1'(`ASP_STATUS_RST >> `ASP_STATUS_RDY);
      gap <= '0;
    end
    else
    begin
      if (wr_ev && wr_addr == `ASP_SEL_MODE)
      begin
        mode <= wr_data[7:0];
      end
      if (wr_ev && wr_addr == `ASP_SEL_FILTER)
      begin
        filter <= wr_data[7:0];
      end
      gap <= (gap != '0) ? gap - 1'b1 : gap;
      if (rd_ev || fifo_pop)
      begin
        rdy_n <= 1'b1;
      end
      // Update wins over a read clear in the same cycle
      if (fifo_load)
      begin
        data <= fifo_od;
        rdy_n <= 1'b0;
        gap <= ($bits(gap))'(UPD_CYC);
      end
    end
  end

  asp_fifo #(.W(16), .D(FIFO_DEPTH)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .in_valid_i(conv_valid_i),
    .in_ready_o(conv_ready_o),
    .in_data_i(conv_data_i),
    .out_valid_o(fifo_ov),
    .out_ready_i(fifo_load),
    .out_data_o(fifo_od)
  );

  rdy_fall_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $fell(rdy_n) |-> $past(fifo_load))
    else $error("ready fell without an update");
  rdy_pre_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    fifo_load |-> rdy_n && !$past(fifo_load))
    else $error("update without ready high first");
  rdy_read_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    rd_ev && !fifo_load && !rst_ev |=> rdy_n ##1 (rdy_n || $past(fifo_load)))
    else $error("ready not high after read");
  oe_idle_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    cs_s[2] && cs_s[1] |=> !dout_oe_o)
    else $error("pin driven while deselected");
  mode_write_a: assert property (@(posedge clk_sys_i) disable iff (reset_i || rst_ev)
    wr_ev && wr_addr == `ASP_SEL_MODE |=> mode == $past(wr_data[7:0]))
    else $error("mode write lost");
  wen_hold_a: assert property (@(posedge sclk_i) disable iff (lrst_s[1])
    !cs_n_i && state == asp_pkg::ASP_COMM && cnt == 5'h00 && din_i && !ones_hit |=> cnt == 5'h00)
    else $error("moved past write gate");
  ones_reset_a: assert property (@(posedge sclk_i) disable iff (lrst_s[1])
    !cs_n_i && ones_hit |=> state == asp_pkg::ASP_COMM && cnt == 5'h00 && rst_tog != $past(rst_tog))
    else $error("ones run did not reset");
  cs_hold_a: assert property (@(posedge sclk_i) disable iff (lrst_s[1])
    cs_n_i |=> $stable(cnt) && $stable(state) && $stable(sel))
    else $error("state moved while deselected");
  rd_shift_a: assert property (@(posedge sclk_i) disable iff (lrst_s[1])
    !cs_n_i && state == asp_pkg::ASP_RD && !ones_hit && idx != 5'h00 |=> idx == $past(idx) - 5'h01)
    else $error("read shift slipped");
endmodule // asp_port

// >>> verification/asp_host.sv
// Serial host model: drives clock, select and data of the converter port.
// Assumes the bench calls xfer; the clock stands still between calls.
`timescale 1ns/1ps
module asp_host (
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o,
  input wire logic dout_i
);
  initial
  begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end
  // One burst of n bits, MSB first; gaps between bursts are legal
  task automatic xfer(input int n, input logic [15:0] wv, input logic cs, output logic [15:0] rv);
    rv = 16'h0000;
    cs_n_o = cs;
    #6;
    for (int i = n - 1; i >= 0; i--)
    begin
      sclk_o = 1'b0;
      din_o = wv[i];
      #6;
      rv = {rv[14:0], dout_i};
      sclk_o = 1'b1;
      #6;
    end
    // Leave no stale level on the data line
    din_o = ~din_o;
  endtask
endmodule // asp_host

// >>> verification/tb_asp_port.sv
// Self-checking bench for the converter serial port.
// Assumes asp_host as serial master; short update gap for speed.
`timescale 1ns/1ps
module tb_asp_port;
  logic clk_sys_i, reset_i, conv_valid_i, sclk, cs_n, din, dout, dout_oe, conv_ready, rdy_n;
  logic [15:0] conv_data_i;
  logic [15:0] r;
  logic [7:0] mode;
  logic [7:0] filter;
  int n_errors = 0;
  int n_tests = 0;
  int k;
  // Released pin shows the inverse, so reading an undriven pin cannot pass
  wire dout_pin = dout_oe ? dout : !dout;
  asp_host host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout_pin));
  asp_port #(.FIFO_DEPTH(16), .UPD_CYC(2)) dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .din_i(din), .dout_o(dout), .dout_oe_o(dout_oe), .conv_valid_i(conv_valid_i),
    .conv_ready_o(conv_ready), .conv_data_i(conv_data_i), .mode_o(mode), .filter_o(filter), .rdy_n_o(rdy_n));
  initial
  begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude;
    if (n_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wreg(input logic [7:0] cmd, input logic [7:0] v);
    host.xfer(8, {8'h00, cmd}, 1'b0, r);
    host.xfer(8, {8'h00, v}, 1'b0, r);
  endtask
  task automatic rreg(input logic [7:0] cmd, input int n);
    host.xfer(8, {8'h00, cmd}, 1'b0, r);
    host.xfer(n, 16'h0000, 1'b0, r);
  endtask
  // Bounded wait for the status ready bit to reach a level
  task automatic wait_rdy(input logic lvl);
    k = 0;
    while (rdy_n !== lvl && k < 200)
    begin
      cyc(1);
      k++;
    end
    if (k == 200)
    begin
      check("wait_rdy", 16'h0001, 16'h0000);
      conclude();
    end
  endtask
  task automatic push(input logic [15:0] v);
    conv_data_i = v;
    conv_valid_i = 1'b1;
    cyc(1);
    conv_valid_i = 1'b0;
    cyc(1);
  endtask
  initial
  begin
    #200000;
    check("timeout", 16'h0001, 16'h0000);
    conclude();
  end
  initial
  begin
    reset_i = 1'b1;
    conv_valid_i = 1'b0;
    conv_data_i = 16'h0000;
    // Link side needs serial edges during reset; cs high so they are ignored
    fork
      host.xfer(3, 16'h0007, 1'b1, r);
      cyc(10);
    join
    cyc(1);
    reset_i = 1'b0;
    // The link sees the release only on its own clock; give it idle edges
    host.xfer(3, 16'h0007, 1'b1, r);
    cyc(2);
    check("mode", {8'h00, mode}, 16'h0002);
    check("filter", {8'h00, filter}, 16'h0004);
    check("rdy_n", {15'h0000, rdy_n}, 16'h0001);
    check("oe", {15'h0000, dout_oe}, 16'h0000);
    check("conv_ready", {15'h0000, conv_ready}, 16'h0001);
    rreg(8'h08, 8);
    check("status", r, 16'h0088);
    check("oe", {15'h0000, dout_oe}, 16'h0001);
    rreg(8'h18, 8);
    check("mode rd", r, 16'h0002);
    wreg(8'h20, 8'h5a);
    cyc(8);
    check("filter", {8'h00, filter}, 16'h005a);
    rreg(8'h28, 8);
    check("filter rd", r, 16'h005a);
    // Gate bits held, then a burst with cs high that must leave no trace
    host.xfer(3, 16'h0007, 1'b0, r);
    host.xfer(4, 16'h0005, 1'b1, r);
    wreg(8'h10, 8'h33);
    cyc(8);
    check("mode", {8'h00, mode}, 16'h0033);
    push(16'hbeef);
    wait_rdy(1'b0);
    check("rdy_n", {15'h0000, rdy_n}, 16'h0000);
    host.xfer(8, 16'h0038, 1'b0, r);
    check("pin rdy", {15'h0000, r[0]}, 16'h0000);
    host.xfer(16, 16'h0000, 1'b0, r);
    check("data rd", r, 16'hbeef);
    cyc(8);
    check("rdy_n", {15'h0000, rdy_n}, 16'h0001);
    push(16'h1111);
    push(16'h2222);
    wait_rdy(1'b0);
    wait_rdy(1'b1);
    wait_rdy(1'b0);
    rreg(8'h38, 16);
    check("data rd", r, 16'h2222);
    // Fill the FIFO faster than the update gap drains it
    cyc(1);
    conv_valid_i = 1'b1;
    for (k = 0; k < 100 && conv_ready === 1'b1; k++)
      cyc(1);
    conv_valid_i = 1'b0;
    check("full", {15'h0000, conv_ready}, 16'h0000);
    cyc(80);
    check("drained", {15'h0000, conv_ready}, 16'h0001);
    host.xfer(16, 16'hffff, 1'b0, r);
    host.xfer(16, 16'hffff, 1'b0, r);
    cyc(10);
    check("mode", {8'h00, mode}, 16'h0002);
    check("filter", {8'h00, filter}, 16'h0004);
    rreg(8'h18, 8);
    check("mode rd", r, 16'h0002);
    host.xfer(0, 16'h0000, 1'b1, r);
    cyc(6);
    check("oe", {15'h0000, dout_oe}, 16'h0000);
    conclude();
  end
endmodule // tb_asp_port
